/* File: pkg/led_info_pkg.sv */
`default_nettype none
package led_info_pkg;

	typedef struct packed
	{
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed
	{
		logic r;
		logic g;
		logic b;
	} led_t;

	localparam int NREG = 10;

	localparam int IDX_OVT  = 0;
	localparam int IDX_UVT  = 1;
	localparam int IDX_BGRN = 2;
	localparam int IDX_BRED = 3;
	localparam int IDX_BBLU = 4;
	localparam int IDX_MODE = 5;
	localparam int IDX_BSRC = 6;
	localparam int IDX_BINV = 7;
	localparam int IDX_COL  = 8;
	localparam int IDX_CLIM = 9;

	// Upper half at the printed register address, lower half at the next one
	localparam logic [15:0] REG_ADDR [0:NREG-1] = '{
		16'h0356, 16'h0358, 16'h03d0, 16'h03d2, 16'h03d4,
		16'h03ea, 16'h03f4, 16'h03f6, 16'h03f8, 16'h138c};
	localparam logic [15:0] LO_HALF_OFS = 16'h0001;

	localparam logic signed [31:0] REG_RESET [0:NREG-1] = '{
		32'h00000276, 32'h0000008c, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000001, 32'h00000080, 32'h00000000, 32'h00000000, 32'h00000003};
	localparam logic signed [31:0] REG_MIN [0:NREG-1] = '{
		32'h0000008c, 32'h0000008c, 32'h00000000, 32'h00000000, 32'h00000000,
		32'hfffffffd, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
	localparam logic signed [31:0] REG_MAX [0:NREG-1] = '{
		32'h00000276, 32'h00000276, 32'h00000009, 32'h00000009, 32'h00000009,
		32'h00000001, 32'h000000ff, 32'h00000001, 32'h00000001, 32'h0000000a};

	localparam logic signed [31:0] MODE_DARK_ALL  = 32'hfffffffd;
	localparam logic signed [31:0] MODE_DARK_ALM  = 32'hfffffffe;
	localparam logic signed [31:0] MODE_DARK_COMM = 32'hffffffff;
	localparam logic signed [31:0] MODE_IO_STATUS = 32'h00000000;
	localparam logic [7:0]         SRC_CONST_OFF  = 8'h80;

	// Timing
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int MS_TICK_NS     = 1000000;
	localparam int MS_TICK_CYCLES = MS_TICK_NS * 1000 / CLK_PERIOD_PS;
	localparam int BOOT_RED_S     = 1;
	localparam int BOOT_RED_MS    = BOOT_RED_S * 1000;
	localparam int BLINK_HALF_MS  = 250;

	localparam led_t LED_OFF = 3'b000;
	localparam led_t LED_RED = 3'b100;
	localparam led_t LED_GRN = 3'b010;
	localparam led_t LED_BLU = 3'b001;

endpackage
`default_nettype wire

/* File: verif/modbus_master_model.sv */
`default_nettype none
module modbus_master_model
(
	input  wire logic                   clk,
	output var  led_info_pkg::reg_req_t req,
	output var  logic                   rd_due
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [17:0] exp_q [$];
	logic        rd_req;

	initial
	begin
		req = '0;
		rd_req = 1'h0;
	end

	// Read data is due one cycle after the address is taken
	always @(posedge clk)
		rd_due <= rd_req;

	// Upper halves are only staged, so they are always acknowledged
	task automatic wr16(input logic [15:0] a, input logic [15:0] d, input logic ok);
		@(negedge clk);
		req = '{wr: 1'h1, addr: a, wdata: d};
		exp_q.push_back(ok ? 18'h10000 : 18'h20000);
		@(negedge clk);
		req.wr = 1'h0;
		req.wdata = ~d;
	endtask

	task automatic wr32(input logic [15:0] a, input logic [31:0] v, input logic ok);
		wr16(a, v[31:16], 1'h1);
		wr16(a + 16'h0001, v[15:0], ok);
	endtask

	task automatic rd16(input logic [15:0] a, input logic [15:0] e);
		@(negedge clk);
		req.addr = a;
		rd_req = 1'h1;
		exp_q.push_back({2'h0, e});
		@(negedge clk);
		rd_req = 1'h0;
	endtask

	task automatic rd32(input logic [15:0] a, input logic [31:0] e);
		rd16(a, e[31:16]);
		rd16(a + 16'h0001, e[15:0]);
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_led_info_param_bank.sv */
`default_nettype none
module tb_led_info_param_bank;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int MS = 2;
	localparam logic [15:0] A_OVT = 16'h0356, A_UVT = 16'h0358, A_MODE = 16'h03ea, A_SRC = 16'h03f4;
	localparam logic [15:0] A_INV = 16'h03f6, A_COL = 16'h03f8, A_LIM = 16'h138c;
	localparam logic [31:0] RST [0:9] = '{32'h276, 32'h8c, 32'h0, 32'h0, 32'h0, 32'h1, 32'h80, 32'h0, 32'h0, 32'h3};

	logic                   clk, nrst, alarm_in, comm_err, comm_err_clear, comm_activity;
	logic                   overvoltage_flag, undervoltage_flag, comm_alarm, wr_ack, wr_reject;
	logic                   probe_req, probe_due;
	logic [15:0]            rdata, bus_voltage;
	logic [255:0]           out_signals;
	logic [17:0]            seen, want;
	led_info_pkg::led_t     pwr_led, communication_led;
	wire led_info_pkg::reg_req_t req;
	wire logic              rd_due;
	int                     n_fail, check_count, cycles, seed, thr, src;
	wire logic [15:0]       obs = {7'h0, overvoltage_flag, undervoltage_flag, comm_alarm, pwr_led, communication_led};

	modbus_master_model m (.clk(clk), .req(req), .rd_due(rd_due));

	led_info_param_bank #(.MS_CYCLES(MS), .NUM_OUT(256)) uut
	(
		.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .wr_ack(wr_ack), .wr_reject(wr_reject),
		.bus_voltage(bus_voltage), .alarm_in(alarm_in), .comm_err(comm_err), .comm_err_clear(comm_err_clear),
		.comm_activity(comm_activity), .out_signals(out_signals), .overvoltage_flag(overvoltage_flag),
		.undervoltage_flag(undervoltage_flag), .comm_alarm(comm_alarm), .pwr_led(pwr_led),
		.communication_led(communication_led)
	);

	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input logic [17:0] s, input logic [17:0] e);
		check_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task automatic wrap_up();
		if (m.exp_q.size() != 0)
			n_fail++;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [15:0] ob(input logic [2:0] f, input logic [2:0] p, input logic [2:0] c);
		return {7'h0, f, p, c};
	endfunction

	// Probe lags by a few cycles so flag and LED registers have settled
	task automatic probe(input logic [15:0] e);
		repeat (3) @(negedge clk);
		probe_req = 1'h1;
		m.exp_q.push_back({2'h3, e});
		@(negedge clk);
		probe_req = 1'h0;
	endtask

	task automatic pulse_err(input int n);
		repeat (n)
		begin
			@(negedge clk);
			comm_err = 1'h1;
			@(negedge clk);
			comm_err = 1'h0;
		end
	endtask

	always @(posedge clk)
		probe_due <= probe_req;

	always @(negedge clk)
	begin
		seen = probe_due ? {2'h3, obs} : rd_due ? {2'h0, rdata} : {wr_reject ? 2'h2 : 2'h1, 16'h0000};
		if (nrst === 1'h1 && (rd_due === 1'h1 || probe_due === 1'h1 || wr_ack !== 1'h0 || wr_reject !== 1'h0))
		begin
			want = (m.exp_q.size() > 0) ? m.exp_q.pop_front() : 18'h3ffff;
			check(seen, want);
		end
	end

	// Hang guard well above the longest run of the sequence
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	initial
	begin
		{nrst, alarm_in, comm_err, comm_err_clear, comm_activity, probe_req} = '0;
		{n_fail, check_count, cycles} = '0;
		seed = 87;
		out_signals = '0;
		bus_voltage = 16'h008c;
		repeat (5) @(negedge clk);
		nrst = 1'h1;
		for (int i = 0; i < led_info_pkg::NREG; i++)
		begin
			m.rd32(led_info_pkg::REG_ADDR[i], RST[i]);
			m.wr32(led_info_pkg::REG_ADDR[i], led_info_pkg::REG_MAX[i], 1'h1);
			m.wr32(led_info_pkg::REG_ADDR[i], led_info_pkg::REG_MAX[i] + 1, 1'h0);
			m.wr32(led_info_pkg::REG_ADDR[i], led_info_pkg::REG_MIN[i] - 1, 1'h0);
			m.rd32(led_info_pkg::REG_ADDR[i], led_info_pkg::REG_MAX[i]);
			m.wr32(led_info_pkg::REG_ADDR[i], RST[i], 1'h1);
		end
		m.wr16(16'h0400, 16'h0001, 1'h0);
		m.rd16(16'h0400, 16'h0000);
		m.wr32(A_MODE, 32'hfffffffd, 1'h1);
		probe(ob(3'h0, 3'h4, 3'h0));
		repeat (MS * 1000) @(negedge clk);
		alarm_in = 1'h1;
		probe(ob(3'h0, 3'h0, 3'h0));
		m.wr32(A_MODE, 32'hfffffffe, 1'h1);
		probe(ob(3'h0, 3'h4, 3'h0));
		alarm_in = 1'h0;
		probe(ob(3'h0, 3'h0, 3'h0));
		comm_activity = 1'h1;
		m.wr32(A_MODE, 32'hffffffff, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h0));
		m.wr32(A_MODE, 32'h1, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h2));
		alarm_in = 1'h1;
		probe(ob(3'h0, 3'h4, 3'h2));
		alarm_in = 1'h0;
		m.wr32(A_COL, 32'h1, 1'h1);
		probe(ob(3'h0, 3'h7, 3'h7));
		m.wr32(A_COL, 32'h0, 1'h1);
		out_signals = '1;
		m.wr32(A_MODE, 32'h0, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h0));
		src = $random(seed) & 32'h7f;
		out_signals = '0;
		out_signals[src] = 1'h1;
		m.wr32(A_SRC, src, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h1));
		m.wr32(A_INV, 32'h1, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h0));
		m.wr32(A_MODE, 32'h1, 1'h1);
		probe(ob(3'h0, 3'h2, 3'h2));
		thr = 140 + (($random(seed) & 32'h7fffffff) % 491);
		m.wr32(A_OVT, thr, 1'h1);
		bus_voltage = 16'(thr + 1);
		probe(ob(3'h4, 3'h2, 3'h2));
		bus_voltage = 16'(thr);
		probe(ob(3'h0, 3'h2, 3'h2));
		bus_voltage = 16'h008b;
		probe(ob(3'h2, 3'h2, 3'h2));
		bus_voltage = 16'h008c;
		m.wr32(A_UVT, 32'h8d, 1'h1);
		probe(ob(3'h2, 3'h2, 3'h2));
		m.wr32(A_UVT, 32'h8c, 1'h1);
		m.wr32(A_LIM, 32'h2, 1'h1);
		pulse_err(1);
		probe(ob(3'h0, 3'h2, 3'h2));
		pulse_err(1);
		probe(ob(3'h1, 3'h4, 3'h4));
		@(negedge clk);
		comm_err_clear = 1'h1;
		@(negedge clk);
		comm_err_clear = 1'h0;
		m.wr32(A_LIM, 32'h0, 1'h1);
		pulse_err(3);
		probe(ob(3'h0, 3'h2, 3'h2));
		m.wr32(A_LIM, 32'h3, 1'h1);
		probe(ob(3'h1, 3'h4, 3'h4));
		@(negedge clk);
		comm_err = 1'h1;
		comm_err_clear = 1'h1;
		@(negedge clk);
		comm_err = 1'h0;
		comm_err_clear = 1'h0;
		probe(ob(3'h0, 3'h2, 3'h2));
		pulse_err(2);
		probe(ob(3'h1, 3'h4, 3'h4));
		repeat (4) @(negedge clk);
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: verilog/boot_blink_seq.sv */
`default_nettype none
module boot_blink_seq
#(
	parameter int HALF_MS = led_info_pkg::BLINK_HALF_MS
)
(
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               ms_tick,
	input  wire logic [3:0]         green_cnt,
	input  wire logic [3:0]         red_cnt,
	input  wire logic [3:0]         blue_cnt,
	output var  logic               active,
	output var  led_info_pkg::led_t led
);

	typedef enum logic [1:0] {ST_GREEN, ST_RED, ST_BLUE, ST_DONE} blink_state_t;

	blink_state_t state_r;
	logic [3:0]   n_r;
	logic [9:0]   ms_r;
	logic         on_r;

	localparam logic [9:0] HALF_LAST = 10'(HALF_MS - 1);

	// Counts are read live so a rewrite during the sequence counts at once
	wire logic [3:0] cur_cnt  = (state_r == ST_GREEN) ? green_cnt :
	                            (state_r == ST_RED)   ? red_cnt   : blue_cnt;
	wire logic       phase_end = (n_r >= cur_cnt);
	wire led_info_pkg::led_t cur_led = (state_r == ST_GREEN) ? led_info_pkg::LED_GRN :
	                                   (state_r == ST_RED)   ? led_info_pkg::LED_RED :
	                                                           led_info_pkg::LED_BLU;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r <= ST_GREEN;
			n_r     <= 4'h0;
			ms_r    <= 10'h000;
			on_r    <= 1'b0;
		end
		else if (ms_tick && state_r != ST_DONE)
		begin
			if (phase_end)
			begin
				n_r  <= 4'h0;
				ms_r <= 10'h000;
				on_r <= 1'b0;
				case (state_r)
					ST_GREEN: state_r <= ST_RED;
					ST_RED:   state_r <= ST_BLUE;
					default:  state_r <= ST_DONE;
				endcase
			end
			else if (ms_r == HALF_LAST)
			begin
				ms_r <= 10'h000;
				on_r <= ~on_r;
				if (on_r)
				begin
					n_r <= n_r + 4'h1;
				end
			end
			else
			begin
				ms_r <= ms_r + 10'h001;
			end
		end
	end

	assign active = (state_r != ST_DONE);
	assign led    = on_r ? cur_led : led_info_pkg::LED_OFF;

	chk_green_phase_end: assert property (@(posedge clk) disable iff (!nrst)
		(ms_tick && state_r == ST_GREEN && n_r >= green_cnt) |=> (state_r == ST_RED && n_r == 4'h0))
		else $error("green phase did not end at its count");
	chk_red_phase_end: assert property (@(posedge clk) disable iff (!nrst)
		(ms_tick && state_r == ST_RED && n_r >= red_cnt) |=> (state_r == ST_BLUE && !on_r))
		else $error("red phase did not end at its count");
	chk_blue_phase_end: assert property (@(posedge clk) disable iff (!nrst)
		(ms_tick && state_r == ST_BLUE && n_r >= blue_cnt) |=> (state_r == ST_DONE) [*2])
		else $error("blue phase did not end at its count");

endmodule
`default_nettype wire

/* File: verilog/led_info_param_bank.sv */
`default_nettype none
module led_info_param_bank
#(
	parameter int MS_CYCLES = led_info_pkg::MS_TICK_CYCLES,
	parameter int NUM_OUT   = 256
)
(
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire led_info_pkg::reg_req_t req,
	output var  logic [15:0]            rdata,
	output var  logic                   wr_ack,
	output var  logic                   wr_reject,
	input  wire logic [15:0]            bus_voltage,
	input  wire logic                   alarm_in,
	input  wire logic                   comm_err,
	input  wire logic                   comm_err_clear,
	input  wire logic                   comm_activity,
	input  wire logic [NUM_OUT-1:0]     out_signals,
	output var  logic                   overvoltage_flag,
	output var  logic                   undervoltage_flag,
	output var  logic                   comm_alarm,
	output var  led_info_pkg::led_t     pwr_led,
	output var  led_info_pkg::led_t     communication_led
);

	localparam int NREG = led_info_pkg::NREG;

	logic signed [31:0] regs_r [0:NREG-1];
	logic [15:0]        hold_r;
	logic [15:0]        rdata_r;
	logic               wr_ack_r;
	logic               wr_reject_r;
	logic               ov_r;
	logic               uv_r;
	logic [3:0]         err_cnt_r;
	logic               comm_alarm_r;
	logic [31:0]        div_r;
	logic               tick_r;
	logic [10:0]        boot_ms_r;
	logic               boot_win_r;
	led_info_pkg::led_t pwr_r;
	led_info_pkg::led_t comm_r;

	logic [NREG-1:0] hi_hit;
	logic [NREG-1:0] lo_hit;
	logic [NREG-1:0] in_rng;
	logic [NREG-1:0] commit;
	logic [15:0]     rd_part [0:NREG-1];

	wire logic signed [31:0] wval = $signed({hold_r, req.wdata});

	// Upper half is staged; the whole word is checked and stored on the lower half
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_reg
			assign hi_hit[gi]  = (req.addr == led_info_pkg::REG_ADDR[gi]);
			assign lo_hit[gi]  = (req.addr == led_info_pkg::REG_ADDR[gi] + led_info_pkg::LO_HALF_OFS);
			assign in_rng[gi]  = (wval >= led_info_pkg::REG_MIN[gi]) && (wval <= led_info_pkg::REG_MAX[gi]);
			assign commit[gi]  = req.wr && lo_hit[gi] && in_rng[gi];
			assign rd_part[gi] = hi_hit[gi] ? regs_r[gi][31:16] :
			                     lo_hit[gi] ? regs_r[gi][15:0]  : 16'h0000;

			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					regs_r[gi] <= led_info_pkg::REG_RESET[gi];
				end
				else if (commit[gi])
				begin
					regs_r[gi] <= wval;
				end
			end
		end
	endgenerate

	logic [15:0] rdata_nxt;
	always_comb
	begin
		rdata_nxt = 16'h0000;
		for (int i = 0; i < NREG; i++)
		begin
			rdata_nxt = rdata_nxt | rd_part[i];
		end
	end

	wire logic any_hi     = |hi_hit;
	wire logic wr_ack_nxt = req.wr && (any_hi || (|commit));

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			hold_r      <= 16'h0000;
			rdata_r     <= 16'h0000;
			wr_ack_r    <= 1'b0;
			wr_reject_r <= 1'b0;
		end
		else
		begin
			if (req.wr && any_hi)
			begin
				hold_r <= req.wdata;
			end
			rdata_r     <= rdata_nxt;
			wr_ack_r    <= wr_ack_nxt;
			wr_reject_r <= req.wr && !wr_ack_nxt;
		end
	end

	// Voltage information flags, compared against live thresholds
	wire logic [31:0] volt_ext = {16'h0000, bus_voltage};
	wire logic ov_nxt = (volt_ext > $unsigned(regs_r[led_info_pkg::IDX_OVT]));
	wire logic uv_nxt = (volt_ext < $unsigned(regs_r[led_info_pkg::IDX_UVT]));

	// Error counter saturates so a long burst cannot wrap under the limit
	wire logic [3:0] err_lim   = regs_r[led_info_pkg::IDX_CLIM][3:0];
	wire logic [3:0] err_inc   = (err_cnt_r == 4'hf) ? err_cnt_r : err_cnt_r + 4'h1;
	wire logic [3:0] err_base  = comm_err_clear ? 4'h0 : err_cnt_r;
	wire logic [3:0] err_nxt   = comm_err ? (comm_err_clear ? 4'h1 : err_inc) : err_base;
	wire logic       alarm_nxt = (err_lim != 4'h0) && (err_nxt >= err_lim);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ov_r         <= 1'b0;
			uv_r         <= 1'b0;
			err_cnt_r    <= 4'h0;
			comm_alarm_r <= 1'b0;
		end
		else
		begin
			ov_r         <= ov_nxt;
			uv_r         <= uv_nxt;
			err_cnt_r    <= err_nxt;
			comm_alarm_r <= alarm_nxt;
		end
	end

	// Millisecond enable and the one-second boot window
	localparam logic [31:0] DIV_LAST  = 32'(MS_CYCLES - 1);
	localparam logic [10:0] BOOT_LAST = 11'(led_info_pkg::BOOT_RED_MS - 1);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			div_r      <= 32'h00000000;
			tick_r     <= 1'b0;
			boot_ms_r  <= 11'h000;
			boot_win_r <= 1'b1;
		end
		else
		begin
			div_r  <= (div_r == DIV_LAST) ? 32'h00000000 : div_r + 32'h00000001;
			tick_r <= (div_r == DIV_LAST);
			if (tick_r && boot_win_r)
			begin
				boot_ms_r  <= boot_ms_r + 11'h001;
				boot_win_r <= (boot_ms_r != BOOT_LAST);
			end
		end
	end

	logic               blink_active;
	led_info_pkg::led_t blink_led;

	boot_blink_seq #(
		.HALF_MS (led_info_pkg::BLINK_HALF_MS)
	) u_blink (
		.clk       (clk),
		.nrst      (nrst),
		.ms_tick   (tick_r),
		.green_cnt (regs_r[led_info_pkg::IDX_BGRN][3:0]),
		.red_cnt   (regs_r[led_info_pkg::IDX_BRED][3:0]),
		.blue_cnt  (regs_r[led_info_pkg::IDX_BBLU][3:0]),
		.active    (blink_active),
		.led       (blink_led)
	);

	// LED selection
	wire logic signed [31:0] mode = regs_r[led_info_pkg::IDX_MODE];
	wire logic m_dark_all  = (mode == led_info_pkg::MODE_DARK_ALL);
	wire logic m_dark_alm  = (mode == led_info_pkg::MODE_DARK_ALM);
	wire logic m_dark_comm = (mode == led_info_pkg::MODE_DARK_COMM);
	wire logic m_io        = (mode == led_info_pkg::MODE_IO_STATUS);
	wire logic pwr_dark    = m_dark_all || m_dark_alm;
	wire logic alarm_act   = alarm_in || comm_alarm_r;

	wire logic white = regs_r[led_info_pkg::IDX_COL][0];
	wire led_info_pkg::led_t lit_led = '{r: white, g: 1'b1, b: white};

	// Source 128 is forced off even if a wider signal vector is wired in
	wire logic [7:0] bsel     = regs_r[led_info_pkg::IDX_BSRC][7:0];
	wire logic       bsel_ok  = (32'(bsel) < NUM_OUT) && (bsel != led_info_pkg::SRC_CONST_OFF);
	wire logic       blue_raw = bsel_ok ? out_signals[bsel] : 1'b0;
	wire logic       blue_sig = blue_raw ^ regs_r[led_info_pkg::IDX_BINV][0];
	wire led_info_pkg::led_t io_led = '{r: 1'b0, g: 1'b0, b: blue_sig};

	wire led_info_pkg::led_t pwr_norm  = alarm_act ? led_info_pkg::LED_RED : lit_led;
	wire led_info_pkg::led_t comm_norm = comm_alarm_r  ? led_info_pkg::LED_RED :
	                                     comm_activity ? lit_led : led_info_pkg::LED_OFF;

	wire led_info_pkg::led_t pwr_nxt =
		!pwr_dark                ? pwr_norm :
		boot_win_r               ? led_info_pkg::LED_RED :
		(m_dark_alm && alarm_act) ? led_info_pkg::LED_RED : led_info_pkg::LED_OFF;

	wire led_info_pkg::led_t comm_nxt =
		(pwr_dark || m_dark_comm) ? led_info_pkg::LED_OFF :
		blink_active              ? blink_led :
		m_io                      ? io_led : comm_norm;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pwr_r  <= led_info_pkg::LED_OFF;
			comm_r <= led_info_pkg::LED_OFF;
		end
		else
		begin
			pwr_r  <= pwr_nxt;
			comm_r <= comm_nxt;
		end
	end

	assign rdata             = rdata_r;
	assign wr_ack            = wr_ack_r;
	assign wr_reject         = wr_reject_r;
	assign overvoltage_flag  = ov_r;
	assign undervoltage_flag = uv_r;
	assign comm_alarm        = comm_alarm_r;
	assign pwr_led           = pwr_r;
	assign communication_led = comm_r;

	chk_ov_flag: assert property (@(posedge clk) disable iff (!nrst)
		(volt_ext > $unsigned(regs_r[led_info_pkg::IDX_OVT])) |=> overvoltage_flag)
		else $error("overvoltage flag missed");
	chk_uv_flag: assert property (@(posedge clk) disable iff (!nrst)
		(volt_ext >= $unsigned(regs_r[led_info_pkg::IDX_UVT])) |=> !undervoltage_flag)
		else $error("undervoltage flag raised above threshold");
	chk_write_applies: assert property (@(posedge clk) disable iff (!nrst)
		(req.wr && lo_hit[led_info_pkg::IDX_OVT] && in_rng[led_info_pkg::IDX_OVT])
		|=> (regs_r[led_info_pkg::IDX_OVT] == $past(wval)) && wr_ack)
		else $error("accepted write not applied");
	chk_reject_keeps: assert property (@(posedge clk) disable iff (!nrst)
		(req.wr && lo_hit[led_info_pkg::IDX_MODE] && !in_rng[led_info_pkg::IDX_MODE])
		|=> $stable(regs_r[led_info_pkg::IDX_MODE]) && wr_reject && !wr_ack)
		else $error("out of range write was stored");
	chk_alarm_limit: assert property (@(posedge clk) disable iff (!nrst)
		(err_lim == 4'h0) |=> !comm_alarm || $past(err_lim) != 4'h0)
		else $error("alarm raised while disabled");
	chk_alarm_raise: assert property (@(posedge clk) disable iff (!nrst)
		(err_lim != 4'h0 && err_cnt_r >= err_lim && !comm_err_clear) |=> comm_alarm)
		else $error("alarm missing at limit");
	chk_dark_all: assert property (@(posedge clk) disable iff (!nrst)
		(m_dark_all && !boot_win_r) |=> (pwr_led == led_info_pkg::LED_OFF)
		&& (communication_led == led_info_pkg::LED_OFF))
		else $error("LED lit in fully dark mode");
	chk_boot_red: assert property (@(posedge clk) disable iff (!nrst)
		(pwr_dark && boot_win_r) |=> (pwr_led == led_info_pkg::LED_RED))
		else $error("boot red missing in dark mode");
	chk_blue_gate: assert property (@(posedge clk) disable iff (!nrst)
		(m_io && !blink_active) |=> (communication_led == {2'b00, $past(blue_sig)}))
		else $error("blue source not shown in mode 0");
	chk_colour_norm: assert property (@(posedge clk) disable iff (!nrst)
		(!pwr_dark && !alarm_act) |=> (pwr_led == {$past(white), 1'b1, $past(white)}))
		else $error("power LED colour wrong");
	chk_uv_raise: assert property (@(posedge clk) disable iff (!nrst)
		(volt_ext < $unsigned(regs_r[led_info_pkg::IDX_UVT])) |=> undervoltage_flag)
		else $error("undervoltage flag missed");
	chk_ov_clear: assert property (@(posedge clk) disable iff (!nrst)
		(volt_ext <= $unsigned(regs_r[led_info_pkg::IDX_OVT])) |=> !overvoltage_flag)
		else $error("overvoltage flag raised below threshold");
	chk_dark_alarm: assert property (@(posedge clk) disable iff (!nrst)
		(m_dark_alm && !boot_win_r) |=> (communication_led == led_info_pkg::LED_OFF)
		&& (pwr_led == ($past(alarm_act) ? led_info_pkg::LED_RED : led_info_pkg::LED_OFF)))
		else $error("LED state wrong in alarm only dark mode");
	chk_dark_comm: assert property (@(posedge clk) disable iff (!nrst)
		m_dark_comm |=> (communication_led == led_info_pkg::LED_OFF))
		else $error("communication LED lit in its dark mode");
	chk_alarm_red: assert property (@(posedge clk) disable iff (!nrst)
		(!pwr_dark && alarm_act) |=> (pwr_led == led_info_pkg::LED_RED))
		else $error("power LED not red on alarm");
	chk_invert_blue: assert property (@(posedge clk) disable iff (!nrst)
		(m_io && !blink_active)
		|=> (communication_led.b == ($past(blue_raw) ^ $past(regs_r[led_info_pkg::IDX_BINV][0]))))
		else $error("blue inversion wrong");
	chk_source_off: assert property (@(posedge clk) disable iff (!nrst)
		(bsel == led_info_pkg::SRC_CONST_OFF) |-> !blue_raw)
		else $error("constant off source not off");
	chk_unmapped_reject: assert property (@(posedge clk) disable iff (!nrst)
		(req.wr && !(|hi_hit) && !(|lo_hit)) |=> (wr_reject && !wr_ack))
		else $error("unmapped write not refused");
	chk_clear_alarm: assert property (@(posedge clk) disable iff (!nrst)
		(comm_err_clear && !comm_err) |=> (!comm_alarm && err_cnt_r == 4'h0))
		else $error("error clear did not clear alarm");
	chk_err_set_wins: assert property (@(posedge clk) disable iff (!nrst)
		(comm_err && comm_err_clear) |=> (err_cnt_r == 4'h1))
		else $error("error lost against clear");
	chk_boot_window: assert property (@(posedge clk) disable iff (!nrst)
		!boot_win_r |=> !boot_win_r)
		else $error("boot window reopened");

endmodule
`default_nettype wire
